// File: hdl/trs_match.sv
module trs_match (
    input  trs_pkg::trs_entry_t top,
    input  wire logic [31:0]    target,
    input  trs_pkg::trs_isa_t   target_isa,
    input  wire logic           target_ns,
    output logic                hit
);
    import trs_pkg::*;

    always_comb begin
        hit = top.valid && (top.addr == target) && (top.isa == target_isa)
              && (top.ns == target_ns);
    end

endmodule

// File: hdl/trs_pkg.sv
package trs_pkg;

    localparam int          RS_DEPTH          = 8;
    localparam int          REG_ADDR_W        = 8;

    // Register byte offsets
    localparam logic [7:0]  REG_MAIN_CTRL     = 8'h00;
    localparam logic [7:0]  REG_CFG_CODE_EXT  = 8'h04;
    localparam logic [7:0]  REG_STATUS        = 8'h08;

    // main_control_register fields
    localparam int          CTRL_RS_EN_POS    = 0;
    localparam int          CTRL_CTX_EN_POS   = 1;
    localparam int          CTRL_REV11_POS    = 2;
    localparam logic        CTRL_RS_EN_RST    = 1'b0;
    localparam logic        CTRL_CTX_EN_RST   = 1'b0;
    localparam logic        CTRL_REV11_RST    = 1'b0;

    // config_code_extension_register fields
    localparam int          CCER_RS_IMPL_POS  = 23;

    // Status fields
    localparam int          STAT_LAST_NS_POS  = 0;
    localparam int          STAT_SEC_PEND_POS = 1;
    localparam logic        LAST_NS_RST       = 1'b0;

    typedef logic [1:0] trs_isa_t;

    typedef enum logic [1:0] {
        WP_DIRECT,
        WP_INDIRECT,
        WP_EXCEPTION,
        WP_EXC_RETURN
    } trs_wp_kind_t;

    typedef enum logic [1:0] {
        ATOM_NONE,
        ATOM_E,
        ATOM_N
    } trs_atom_t;

    typedef enum logic [2:0] {
        SLOT_HOLD,
        SLOT_PUSH,
        SLOT_POP,
        SLOT_REPLACE,
        SLOT_CLEAR
    } trs_slot_op_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        trs_isa_t    isa;
        logic        ns;
    } trs_entry_t;

    typedef struct packed {
        logic         valid;
        trs_wp_kind_t kind;
        logic         link;
        logic         cond_pass;
        logic [31:0]  target;
        trs_isa_t     target_isa;
        logic         target_ns;
        logic         hyp_change;
        logic [31:0]  ret_addr;
        trs_isa_t     ret_isa;
        logic         ret_ns;
        logic         wpu_needed;
        logic [31:0]  ctx_id;
    } trs_wp_t;

    typedef struct packed {
        logic        valid;
        logic        wpu;
        logic        branch;
        logic        exc;
        logic        ctx;
        trs_atom_t   atom;
        logic [31:0] addr;
        trs_isa_t    isa;
        logic        ns;
        logic [31:0] ctx_id;
    } trs_trace_rec_t;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [REG_ADDR_W-1:0] addr;
        logic [31:0]           wdata;
    } trs_reg_req_t;

endpackage

// File: hdl/trs_slot.sv
module trs_slot #(
    parameter bit TOP = 1'b0
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  trs_pkg::trs_slot_op_t      op,
    input  trs_pkg::trs_entry_t        newer,
    input  trs_pkg::trs_entry_t        older,
    output trs_pkg::trs_entry_t        entry
);
    import trs_pkg::*;

    trs_entry_t ent_r;
    trs_entry_t ent_nxt;

    always_comb begin
        ent_nxt = ent_r;
        case (op)
            SLOT_PUSH:    ent_nxt = newer;
            SLOT_POP:     ent_nxt = older;
            // Top swaps in the new entry, the rest stay put
            SLOT_REPLACE: ent_nxt = TOP ? newer : ent_r;
            SLOT_CLEAR:   ent_nxt = '0;
            default:      ent_nxt = ent_r;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ent_r <= '0;
        end else begin
            ent_r <= ent_nxt;
        end
    end

    assign entry = ent_r;

endmodule

// File: hdl/trs_trace_ctl.sv
module trs_trace_ctl (
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  trs_pkg::trs_reg_req_t    reg_req,
    output logic [31:0]              reg_rdata,
    input  trs_pkg::trs_wp_t         wp,
    input  wire logic                sec_update,
    input  wire logic                isync_emit,
    output trs_pkg::trs_trace_rec_t  trace_out
);
    import trs_pkg::*;

    typedef struct packed {
        logic           rs_en;
        logic           ctx_en;
        logic           rev11;
        logic           last_ns;
        logic           sec_pending;
        logic           ctx_known;
        logic [31:0]    last_ctx;
        trs_trace_rec_t out;
        logic [31:0]    rdata;
    } trs_state_t;

    trs_state_t   s_r;
    trs_state_t   s_nxt;

    trs_entry_t   ent    [RS_DEPTH];
    trs_entry_t   older  [RS_DEPTH];
    trs_entry_t   newer  [RS_DEPTH];
    trs_entry_t   push_entry;
    trs_slot_op_t slot_op;
    logic         top_hit;

    // Stack as a shift chain, slot 0 holds the most recent entry
    genvar gi;
    generate
        for (gi = 0; gi < RS_DEPTH; gi++) begin : g_slot
            if (gi == 0) begin : g_top
                assign newer[gi] = push_entry;
            end else begin : g_mid
                assign newer[gi] = ent[gi-1];
            end
            if (gi == RS_DEPTH - 1) begin : g_bot
                // Oldest entry falls off the bottom on a push
                assign older[gi] = '0;
            end else begin : g_up
                assign older[gi] = ent[gi+1];
            end
            trs_slot #(
                .TOP   (gi == 0)
            ) u_slot (
                .ref_clk (ref_clk),
                .rst_n   (rst_n),
                .op      (slot_op),
                .newer   (newer[gi]),
                .older   (older[gi]),
                .entry   (ent[gi])
            );
        end
    endgenerate

    trs_match u_match (
        .top        (ent[0]),
        .target     (wp.target),
        .target_isa (wp.target_isa),
        .target_ns  (wp.target_ns),
        .hit        (top_hit)
    );

    always_comb begin
        logic is_ind;
        logic taken;
        logic sec_chg;
        logic no_match;
        logic predict;
        logic emit_branch;
        logic do_pop;
        logic do_push;
        logic push_bad;
        logic ns_after;
        logic [31:0] rval;

        s_nxt       = s_r;
        is_ind      = 1'b0;
        taken       = 1'b0;
        sec_chg     = 1'b0;
        no_match    = 1'b0;
        predict     = 1'b0;
        emit_branch = 1'b0;
        do_pop      = 1'b0;
        do_push     = 1'b0;
        push_bad    = 1'b0;
        ns_after    = s_r.last_ns;
        rval        = '0;
        push_entry  = '0;
        slot_op     = SLOT_HOLD;

        s_nxt.out   = '0;
        s_nxt.rdata = '0;

        // Register writes
        if (reg_req.wr && reg_req.addr == REG_MAIN_CTRL) begin
            s_nxt.rs_en  = reg_req.wdata[CTRL_RS_EN_POS];
            s_nxt.ctx_en = reg_req.wdata[CTRL_CTX_EN_POS];
            s_nxt.rev11  = reg_req.wdata[CTRL_REV11_POS];
        end

        // Register reads, answered one cycle later only
        if (reg_req.rd) begin
            case (reg_req.addr)
                REG_MAIN_CTRL: begin
                    rval[CTRL_RS_EN_POS]  = s_r.rs_en;
                    rval[CTRL_CTX_EN_POS] = s_r.ctx_en;
                    rval[CTRL_REV11_POS]  = s_r.rev11;
                end
                REG_CFG_CODE_EXT: begin
                    rval[CCER_RS_IMPL_POS] = (RS_DEPTH != 0);
                end
                REG_STATUS: begin
                    // Depth and fill level stay hidden
                    rval[STAT_LAST_NS_POS]  = s_r.last_ns;
                    rval[STAT_SEC_PEND_POS] = s_r.sec_pending;
                end
                default: rval = '0;
            endcase
            s_nxt.rdata = rval;
        end

        // Waypoint classification
        is_ind  = (wp.kind == WP_INDIRECT) || (wp.kind == WP_EXC_RETURN);
        taken   = wp.cond_pass || (wp.kind == WP_EXCEPTION);
        sec_chg = s_r.sec_pending || (wp.target_ns != s_r.last_ns);

        // Later revision never predicts special waypoints
        no_match = s_r.rev11 && ((wp.kind == WP_EXC_RETURN) || wp.hyp_change
                   || sec_chg);

        // Prediction only for passing indirect branches and exception returns
        predict = s_r.rs_en && is_ind && wp.cond_pass && top_hit
                  && !sec_chg && !no_match;

        if (wp.valid) begin
            s_nxt.out.valid = 1'b1;
            case (wp.kind)
                WP_EXCEPTION: begin
                    // Stack neither compared nor touched here
                    emit_branch   = 1'b1;
                    s_nxt.out.exc = 1'b1;
                    s_nxt.out.wpu = wp.wpu_needed;
                end
                WP_INDIRECT, WP_EXC_RETURN: begin
                    if (!wp.cond_pass) begin
                        s_nxt.out.atom = ATOM_N;
                    end else if (predict) begin
                        // E atom stands in for the branch packet
                        s_nxt.out.atom = ATOM_E;
                        do_pop         = 1'b1;
                    end else begin
                        emit_branch = 1'b1;
                    end
                end
                WP_DIRECT: begin
                    if (!wp.cond_pass) begin
                        // Security report stays pending
                        s_nxt.out.atom = ATOM_N;
                    end else if (sec_chg) begin
                        emit_branch = 1'b1;
                    end else begin
                        s_nxt.out.atom = ATOM_E;
                    end
                end
                default: s_nxt.out.valid = 1'b0;
            endcase

            if (emit_branch) begin
                // Branch packet carries the target security state
                s_nxt.out.branch  = 1'b1;
                s_nxt.out.addr    = wp.target;
                s_nxt.out.isa     = wp.target_isa;
                s_nxt.out.ns      = wp.target_ns;
                s_nxt.sec_pending = 1'b0;
                ns_after          = wp.target_ns;
                // A return to Secure before any report hides NS
                s_nxt.last_ns     = wp.target_ns;
                if (s_r.ctx_en && (!s_r.ctx_known || wp.ctx_id != s_r.last_ctx)) begin
                    s_nxt.out.ctx    = 1'b1;
                    s_nxt.out.ctx_id = wp.ctx_id;
                    s_nxt.last_ctx   = wp.ctx_id;
                    s_nxt.ctx_known  = 1'b1;
                end
            end

            // Push after compare, whatever its outcome
            do_push = s_r.rs_en && wp.link && wp.cond_pass
                      && ((wp.kind == WP_DIRECT) || (wp.kind == WP_INDIRECT));
            push_bad = do_push && (wp.ret_ns != ns_after);
        end

        // Change made by a register write shows only later
        if (sec_update) begin
            s_nxt.sec_pending = 1'b1;
        end

        push_entry.valid = 1'b1;
        push_entry.addr  = wp.ret_addr;
        push_entry.isa   = wp.ret_isa;
        push_entry.ns    = wp.ret_ns;

        // Clear beats every other stack operation
        if (!s_r.rs_en || isync_emit) begin
            slot_op = SLOT_CLEAR;
        end else if (push_bad) begin
            slot_op = SLOT_CLEAR;
        end else if (do_pop && do_push) begin
            slot_op = SLOT_REPLACE;
        end else if (do_push) begin
            slot_op = SLOT_PUSH;
        end else if (do_pop) begin
            slot_op = SLOT_POP;
        end else begin
            slot_op = SLOT_HOLD;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r             <= '0;
            s_r.rs_en       <= CTRL_RS_EN_RST;
            s_r.ctx_en      <= CTRL_CTX_EN_RST;
            s_r.rev11       <= CTRL_REV11_RST;
            s_r.last_ns     <= LAST_NS_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign trace_out = s_r.out;
    assign reg_rdata = s_r.rdata;

endmodule

// File: verification/trs_core_model.sv
module trs_core_model
    import trs_pkg::*;
(
    input wire logic         ref_clk,
    output trs_pkg::trs_wp_t wp
);
    timeunit 1ns;
    timeprecision 1ps;

    initial wp = '0;

    // Gap cycles show inverted fields with valid clear; with gap 0 the last waypoint stays valid on wp until the next send
    task automatic send(input trs_wp_t w, input int gap);
        trs_wp_t idle;
        idle = trs_wp_t'(~w);
        idle.valid = 1'b0;
        wp <= w;
        @(posedge ref_clk);
        if (gap > 0) begin
            wp <= idle;
            repeat (gap) @(posedge ref_clk);
        end
    endtask
endmodule

// File: verification/trs_trace_ctl_asserts.sv
module trs_trace_ctl_asserts
    import trs_pkg::*;
(
    input wire logic               ref_clk,
    input wire logic               rst_n,
    input trs_pkg::trs_reg_req_t   reg_req,
    input wire logic [31:0]        reg_rdata,
    input trs_pkg::trs_wp_t        wp,
    input wire logic               sec_update,
    input wire logic               isync_emit,
    input trs_pkg::trs_trace_rec_t trace_out
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_one_rec: assert property (wp.valid |=> trace_out.valid)
        else $error("record missing");
    a_no_spur: assert property (!wp.valid |=> !trace_out.valid)
        else $error("spurious record");
    a_exc_branch: assert property (wp.valid && wp.kind == WP_EXCEPTION
        |=> trace_out.branch && trace_out.exc && trace_out.atom != ATOM_E)
        else $error("exception not a branch");
    a_nt_atom: assert property (wp.valid && wp.kind == WP_DIRECT && !wp.cond_pass
        |=> trace_out.atom == ATOM_N && !trace_out.branch)
        else $error("not-taken without N atom");
    a_sec_force: assert property (sec_update ##1 (wp.valid && wp.kind == WP_DIRECT
        && wp.cond_pass) |=> trace_out.branch)
        else $error("pending change not reported");
    a_br_addr: assert property (trace_out.branch |-> trace_out.addr == $past(wp.target)
        && trace_out.ns == $past(wp.target_ns))
        else $error("branch target wrong");
    a_e_cause: assert property (trace_out.atom == ATOM_E |-> !trace_out.branch
        && $past(wp.cond_pass) && $past(wp.kind) != WP_EXCEPTION)
        else $error("E atom without cause");
    a_ctx_follow: assert property (trace_out.ctx |-> trace_out.branch)
        else $error("context without branch");
    a_ccer_impl: assert property (reg_req.rd && reg_req.addr == REG_CFG_CODE_EXT
        |=> reg_rdata[CCER_RS_IMPL_POS])
        else $error("stack implemented bit clear");

    c_e_atom: cover property (trace_out.atom == ATOM_E);
    c_n_atom: cover property (trace_out.atom == ATOM_N);
    c_ctx: cover property (trace_out.ctx);
endmodule

bind trs_trace_ctl trs_trace_ctl_asserts i_trs_trace_ctl_asserts (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .reg_req    (reg_req),
    .reg_rdata  (reg_rdata),
    .wp         (wp),
    .sec_update (sec_update),
    .isync_emit (isync_emit),
    .trace_out  (trace_out)
);

// File: verification/trs_trace_ctl_tb_top.sv
module trs_trace_ctl_tb_top
    import trs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic           ref_clk = 1'b0;
    logic           rst_n = 1'b0;
    trs_reg_req_t   reg_req = '0;
    logic [31:0]    reg_rdata;
    trs_wp_t        wp;
    logic           sec_update = 1'b0;
    logic           isync_emit = 1'b0;
    trs_trace_rec_t trace_out;
    int             fail_count = 0;
    int             cmp_count = 0;
    int             cyc = 0;
    logic [34:0]    stk[$];
    logic [31:0]    lctx, e_addr, d;
    logic [2:0]     ctl, e_st;
    logic           m_ns, pend, hctx, e_v, e_b, e_x, e_c, e_w, ind, chg;
    trs_atom_t      e_a;

    always #12.5 ref_clk = ~ref_clk;

    trs_trace_ctl i_trs_trace_ctl (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .reg_req    (reg_req),
        .reg_rdata  (reg_rdata),
        .wp         (wp),
        .sec_update (sec_update),
        .isync_emit (isync_emit),
        .trace_out  (trace_out)
    );
    trs_core_model i_trs_core_model (
        .ref_clk (ref_clk),
        .wp      (wp)
    );

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        reg_req.wr <= 1'b1;
        reg_req.addr <= a;
        reg_req.wdata <= v;
        @(posedge ref_clk);
        reg_req.wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic reg_rd(input logic [7:0] a);
        reg_req.rd <= 1'b1;
        reg_req.addr <= a;
        @(posedge ref_clk);
        reg_req.rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask

    // ISA states ride on address bits so equal addresses carry equal ISA states; target NS comes from s, return NS from s xor r[4]
    task automatic cwp(input trs_wp_kind_t k, input logic l, input logic p,
                       input logic [31:0] t, input logic [31:0] r, input logic s, input int g);
        trs_wp_t w;
        w = '0;
        w.valid = 1'b1;
        w.kind = k;
        w.link = l;
        w.cond_pass = p;
        w.target = t;
        w.target_isa = t[9:8];
        w.target_ns = s;
        w.hyp_change = t[3];
        w.wpu_needed = t[2];
        w.ret_addr = r;
        w.ret_isa = r[9:8];
        w.ret_ns = s ^ r[4];
        w.ctx_id = 32'(r[2]);
        i_trs_core_model.send(w, g);
    endtask

    function automatic logic [31:0] pick();
        return 32'h200 + 32'(4 * ($urandom % 5));
    endfunction

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            stk.delete();
            ctl = 3'h0;
            m_ns = 1'b0;
            pend = 1'b0;
            hctx = 1'b0;
            e_v = 1'b0;
        end else begin
            chk("valid", 32'(trace_out.valid), 32'(e_v));
            if (e_v) chk("kind", 32'({trace_out.wpu, trace_out.branch, trace_out.exc,
                trace_out.ctx}), 32'({e_w, e_b, e_x, e_c}));
            if (e_v) chk("atom", 32'(trace_out.atom), 32'(e_a));
            if (e_v && e_b) chk("target", trace_out.addr, e_addr);
            if (e_v && e_b) chk("tstate", 32'({trace_out.isa, trace_out.ns}), 32'(e_st));
            if (e_v && e_c) chk("ctx_id", trace_out.ctx_id, lctx);
            e_v = wp.valid;
            if (wp.valid) begin
                ind = wp.kind inside {WP_INDIRECT, WP_EXC_RETURN};
                chg = pend || wp.target_ns !== m_ns;
                e_x = wp.kind == WP_EXCEPTION;
                e_w = e_x && wp.wpu_needed;
                e_b = 1'b0;
                e_a = ATOM_NONE;
                if (e_x) e_b = 1'b1;
                else if (!wp.cond_pass) e_a = ATOM_N;
                else if (!ind) e_b = chg;
                else if (ctl[0] && stk.size() > 0 && !chg
                         && stk[$] === {wp.target_ns, wp.target_isa, wp.target}
                         && !(ctl[2] && (wp.kind == WP_EXC_RETURN || wp.hyp_change))) begin
                    e_a = ATOM_E;
                    void'(stk.pop_back());
                end else e_b = 1'b1;
                if (!e_x && wp.cond_pass && !ind && !chg) e_a = ATOM_E;
                if (e_b) begin
                    e_addr = wp.target;
                    e_st = {wp.target_isa, wp.target_ns};
                    m_ns = wp.target_ns;
                    pend = 1'b0;
                end
                e_c = ctl[1] && e_b && (!hctx || wp.ctx_id !== lctx);
                if (e_c) lctx = wp.ctx_id;
                hctx = hctx || e_c;
                if (ctl[0] && wp.link && wp.cond_pass
                    && wp.kind inside {WP_DIRECT, WP_INDIRECT}) begin
                    if (wp.ret_ns !== m_ns) stk.delete();
                    else if (stk.size() == RS_DEPTH) void'(stk.pop_front());
                    if (wp.ret_ns === m_ns) stk.push_back({wp.ret_ns, wp.ret_isa, wp.ret_addr});
                end
            end
            if (sec_update) pend = 1'b1;
            if (isync_emit || !ctl[0]) stk.delete();
            if (reg_req.wr && reg_req.addr == REG_MAIN_CTRL) ctl = reg_req.wdata[2:0];
        end
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(32'h3182));
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        reg_rd(REG_MAIN_CTRL);
        chk("ctrl_reset", d, 32'h0);
        reg_wr(REG_CFG_CODE_EXT, 32'h0);
        reg_rd(REG_CFG_CODE_EXT);
        chk("stack_impl", 32'(d[CCER_RS_IMPL_POS]), 32'h1);
        reg_rd(8'h3c);
        chk("unmapped", d, 32'h0);
        cwp(WP_DIRECT, 1'b1, 1'b1, 32'h40, 32'h1000, 1'b0, 0);
        cwp(WP_INDIRECT, 1'b0, 1'b1, 32'h1000, 32'h0, 1'b0, 1);
        reg_wr(REG_MAIN_CTRL, 32'h3);
        for (int i = 0; i <= RS_DEPTH; i++) begin
            cwp(WP_DIRECT, 1'b1, 1'b1, 32'h40, 32'h1000 + 32'(i * 32), 1'b0, 0);
        end
        for (int i = RS_DEPTH; i >= 0; i--) begin
            cwp(WP_INDIRECT, 1'b0, 1'b1, 32'h1000 + 32'(i * 32), 32'h0, 1'b0, 0);
        end
        cwp(WP_DIRECT, 1'b1, 1'b1, 32'h40, 32'h2000, 1'b0, 0);
        cwp(WP_INDIRECT, 1'b1, 1'b1, 32'h2000, 32'h2004, 1'b0, 0);
        cwp(WP_EXCEPTION, 1'b0, 1'b1, 32'h18, 32'h0, 1'b0, 0);
        cwp(WP_INDIRECT, 1'b0, 1'b1, 32'h2004, 32'h0, 1'b0, 1);
        for (int k = 0; k < 3; k++) begin
            sec_update <= 1'b1;
            @(posedge ref_clk);
            sec_update <= 1'b0;
            cwp(k == 0 ? WP_EXCEPTION : WP_DIRECT, 1'b0, k != 1, 32'h80, 32'h0, k == 1, 1);
            if (k == 1) begin
                reg_rd(REG_STATUS);
                chk("status", d, 32'({pend, m_ns}));
            end
        end
        // Entry pushed before a mid-run reset must not predict afterwards
        cwp(WP_DIRECT, 1'b1, 1'b1, 32'h40, 32'h3000, 1'b0, 1);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        reg_rd(REG_MAIN_CTRL);
        chk("ctrl_rerun", d, 32'h0);
        reg_wr(REG_MAIN_CTRL, 32'h1);
        cwp(WP_INDIRECT, 1'b0, 1'b1, 32'h3000, 32'h0, 1'b0, 1);
        for (int n = 0; n < 1500; n++) begin
            isync_emit <= ($urandom % 16) == 0;
            case ($urandom % 32)
                0: reg_wr(($urandom % 4) == 0 ? 8'h20 : REG_MAIN_CTRL, 32'($urandom % 8));
                1: begin
                    sec_update <= 1'b1;
                    @(posedge ref_clk);
                    sec_update <= 1'b0;
                    @(posedge ref_clk);
                end
                default: cwp(trs_wp_kind_t'(2'($urandom)), 1'($urandom), ($urandom % 4) != 0,
                             pick(), pick(), m_ns ^ (($urandom % 8) == 0), int'($urandom % 2));
            endcase
        end
        isync_emit <= 1'b0;
        cwp(WP_DIRECT, 1'b0, 1'b0, 32'h40, 32'h0, 1'b0, 2);
        tally_and_finish();
    end
endmodule
